// *** verilog/sbcs_pkg.sv ***
package sbcs_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int NUM_PAIRS = 4;
  localparam int PAIR_W   = 2;
  localparam int NIBBLE_W = 4;
  localparam int SEQ_LEN  = 8;
  localparam int IDX_W    = 3;
  localparam int IRQ_W    = 3;
  localparam int CTRL_W   = 3;

  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0c;

  localparam int CTRL_ACK_MODE_BIT   = 0;
  localparam int CTRL_WARN_DIRTY_BIT = 1;
  localparam int CTRL_WARN_FIELD_BIT = 2;
  localparam int CTRL_RESTART_BIT    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h6;

  localparam int ST_SAFE_BIT  = 0;
  localparam int ST_WARN_BIT  = 1;
  localparam int ST_STATE_LSB = 2;
  localparam int ST_PAIR_LSB  = 4;
  localparam int ST_IDX_LSB   = 6;

  localparam int IRQ_TRIP_BIT    = 0;
  localparam int IRQ_WARN_BIT    = 1;
  localparam int IRQ_RELEASE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // arbitrary per-slave code table, entry 0 in the low nibble
  localparam logic [NIBBLE_W*SEQ_LEN-1:0] CODE_TABLE_DEFAULT = 32'h5ac3_69a5;

  typedef enum logic [1:0] {
    SBCS_TRIPPED  = 2'b00,
    SBCS_WAIT_ACK = 2'b01,
    SBCS_FREE     = 2'b11
  } sbcs_state_type;
endpackage : sbcs_pkg

// *** verilog/sbcs_seq_if.sv ***
`timescale 1ns/1ps
interface sbcs_seq_if;
  import sbcs_pkg::*;
  logic                free;
  logic                poll;
  logic [NIBBLE_W-1:0] code;
  logic [IDX_W-1:0]    idx;
  logic                wrap;
  modport seq  (input free, input poll, output code, output idx, output wrap);
  modport user (output free, output poll, input code, input idx, input wrap);
endinterface : sbcs_seq_if

// *** verilog/sbcs_code_seq.sv ***
`timescale 1ns/1ps
module sbcs_code_seq #(
  parameter logic [sbcs_pkg::NIBBLE_W*sbcs_pkg::SEQ_LEN-1:0] CODE_TABLE = sbcs_pkg::CODE_TABLE_DEFAULT
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  sbcs_seq_if.seq   seq_if
);
  import sbcs_pkg::*;

  logic [IDX_W-1:0]    idx_reg;
  logic [IDX_W-1:0]    idx_next;
  logic [NIBBLE_W-1:0] code_reg;
  logic [NIBBLE_W-1:0] code_next;

  function automatic logic [NIBBLE_W-1:0] table_entry(input logic [IDX_W-1:0] i);
    table_entry = CODE_TABLE[i*NIBBLE_W +: NIBBLE_W];
  endfunction : table_entry

  always_comb
  begin
    if (!seq_if.free)
      idx_next = '0;
    else if (seq_if.poll)
      idx_next = IDX_W'(idx_reg + 3'h1);
    else
      idx_next = idx_reg;
    // not free: static zero word; free: table entry of the fixed code
    code_next = seq_if.free ? table_entry(idx_next) : 4'h0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idx_reg  <= '0;
      code_reg <= 4'h0;
    end
    else
    begin
      idx_reg  <= idx_next;
      code_reg <= code_next;
    end
  end

  assign seq_if.idx  = idx_reg;
  assign seq_if.code = code_reg;
  assign seq_if.wrap = seq_if.free && seq_if.poll && (idx_reg == 3'h7);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_last_entry_sent;
    seq_if.wrap;
  endsequence

  seq_advance_a: assert property (seq_if.free && seq_if.poll |=> idx_reg == IDX_W'($past(idx_reg) + 3'h1))
    else $error("index did not advance on poll");
  seq_hold_a: assert property (seq_if.free && !seq_if.poll |=> $stable(idx_reg))
    else $error("index moved without a poll");
  seq_wrap_a: assert property (s_last_entry_sent ##1 seq_if.free |-> idx_reg == 3'h0 && code_reg == table_entry(3'h0))
    else $error("sequence did not wrap to first entry");
  code_table_a: assert property (seq_if.free |=> code_reg == table_entry(idx_reg))
    else $error("code does not match table entry");
endmodule : sbcs_code_seq

// *** verilog/sbcs_top.sv ***
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module sbcs_top #(
  parameter logic [sbcs_pkg::NIBBLE_W*sbcs_pkg::SEQ_LEN-1:0] CODE_TABLE = sbcs_pkg::CODE_TABLE_DEFAULT
) (
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  input  wire logic [sbcs_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [sbcs_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [sbcs_pkg::DATA_W-1:0]    rd_data_o,
  input  wire logic [sbcs_pkg::PAIR_W-1:0]    field_sel_i,
  input  wire logic [sbcs_pkg::NUM_PAIRS-1:0] protect_hit_i,
  input  wire logic [sbcs_pkg::NUM_PAIRS-1:0] warn_hit_i,
  input  wire logic                           window_dirty_i,
  input  wire logic                           restart_button_i,
  input  wire logic                           poll_done_i,
  output logic                                safety_switch_output_o,
  output logic                                warning_flag_o,
  output logic                                slave_input_bit_zero_o,
  output logic                                slave_input_bit_one_o,
  output logic                                slave_input_bit_two_o,
  output logic                                slave_input_bit_three_o,
  output logic                                irq_o
);
  import sbcs_pkg::*;

  logic                 rst_meta_reg;
  logic                 rst_n_reg;
  sbcs_state_type       state_reg;
  sbcs_state_type       state_next;
  logic                 safe_reg;
  logic                 warn_reg;
  logic                 warn_next;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [IRQ_W-1:0]     irq_stat_reg;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [IRQ_W-1:0]     irq_event;
  logic [DATA_W-1:0]    rd_data_reg;
  logic [DATA_W-1:0]    status_word;
  logic                 viol;
  logic                 warn_field_hit;
  logic                 restart_req;
  logic                 ack_mode;

  sbcs_seq_if seq_bus ();

  // asynchronous assert, synchronous release
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // one selector picks both fields of a pair
  assign viol           = protect_hit_i[field_sel_i];
  assign warn_field_hit = warn_hit_i[field_sel_i];
  assign ack_mode       = ctrl_reg[CTRL_ACK_MODE_BIT];
  assign restart_req    = restart_button_i || (wr_i && addr_i == CTRL_OFS && wr_data_i[CTRL_RESTART_BIT]);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SBCS_FREE:
      begin
        if (viol)
          state_next = SBCS_TRIPPED;
      end
      SBCS_TRIPPED:
      begin
        // release is never possible while the field is occupied
        if (!viol)
          state_next = ack_mode ? SBCS_WAIT_ACK : SBCS_FREE;
      end
      SBCS_WAIT_ACK:
      begin
        if (viol)
          state_next = SBCS_TRIPPED;
        else if (restart_req)
          state_next = SBCS_FREE;
      end
      default:
        state_next = SBCS_TRIPPED;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= SBCS_TRIPPED;
      safe_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      safe_reg  <= (state_next == SBCS_FREE);
    end
  end

  // warning is informative only, it never enters the state machine
  assign warn_next = (ctrl_reg[CTRL_WARN_DIRTY_BIT] && window_dirty_i)
                   || (ctrl_reg[CTRL_WARN_FIELD_BIT] && warn_field_hit);

  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      warn_reg <= 1'b0;
    else
      warn_reg <= warn_next;
  end

  assign seq_bus.free = (state_reg == SBCS_FREE);
  assign seq_bus.poll = poll_done_i;

  sbcs_code_seq #(
    .CODE_TABLE (CODE_TABLE)
  ) u_code_seq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_reg),
    .seq_if  (seq_bus)
  );

  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      ctrl_reg <= CTRL_RST;
    else if (wr_i && addr_i == CTRL_OFS)
      ctrl_reg <= wr_data_i[CTRL_W-1:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      irq_mask_reg <= IRQ_MASK_RST;
    else if (wr_i && addr_i == IRQ_MASK_OFS)
      irq_mask_reg <= wr_data_i[IRQ_W-1:0];
  end

  always_comb
  begin
    irq_event                  = '0;
    irq_event[IRQ_TRIP_BIT]    = (state_reg == SBCS_FREE) && (state_next == SBCS_TRIPPED);
    irq_event[IRQ_WARN_BIT]    = warn_next && !warn_reg;
    irq_event[IRQ_RELEASE_BIT] = (state_reg != SBCS_FREE) && (state_next == SBCS_FREE);
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      irq_stat_reg <= '0;
    else if (wr_i && addr_i == IRQ_STAT_OFS)
      irq_stat_reg <= (irq_stat_reg & ~wr_data_i[IRQ_W-1:0]) | irq_event;
    else
      irq_stat_reg <= irq_stat_reg | irq_event;
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  always_comb
  begin
    status_word                                 = '0;
    status_word[ST_SAFE_BIT]                    = safe_reg;
    status_word[ST_WARN_BIT]                    = warn_reg;
    status_word[ST_STATE_LSB +: 2]              = state_reg;
    status_word[ST_PAIR_LSB +: PAIR_W]          = field_sel_i;
    status_word[ST_IDX_LSB +: IDX_W]            = seq_bus.idx;
  end

  // data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rd_data_reg <= '0;
    else if (rd_i)
    begin
      unique case (addr_i)
        CTRL_OFS:     rd_data_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
        STATUS_OFS:   rd_data_reg <= status_word;
        IRQ_STAT_OFS: rd_data_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
        IRQ_MASK_OFS: rd_data_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
        default:      rd_data_reg <= '0;
      endcase
    end
    else
      rd_data_reg <= '0;
  end

  assign rd_data_o               = rd_data_reg;
  assign safety_switch_output_o  = safe_reg;
  assign warning_flag_o          = warn_reg;
  assign slave_input_bit_zero_o  = seq_bus.code[0];
  assign slave_input_bit_one_o   = seq_bus.code[1];
  assign slave_input_bit_two_o   = seq_bus.code[2];
  assign slave_input_bit_three_o = seq_bus.code[3];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_reg);

  sequence s_clear_field;
    !viol && state_reg == SBCS_TRIPPED;
  endsequence

  sequence s_waiting_no_ack;
    state_reg == SBCS_WAIT_ACK && !restart_req;
  endsequence

  trip_drop_a: assert property (viol |=> !safety_switch_output_o)
    else $error("safety output on during protective field violation");
  release_clear_a: assert property ($rose(safety_switch_output_o) |-> !$past(viol))
    else $error("release while protective field occupied");
  auto_release_a: assert property (s_clear_field ##0 !ack_mode |=> safety_switch_output_o)
    else $error("automatic mode did not release on clear field");
  ack_hold_a: assert property (s_waiting_no_ack |=> !safety_switch_output_o)
    else $error("released without acknowledgement");
  warn_no_trip_a: assert property (seq_bus.free && !viol && warn_field_hit |=> safety_switch_output_o)
    else $error("warning field switched safety output off");
  warn_field_a: assert property (ctrl_reg[CTRL_WARN_FIELD_BIT] && warn_hit_i[field_sel_i] |=> warning_flag_o)
    else $error("selected warning field hit not flagged");
  warn_dirty_a: assert property (!ctrl_reg[CTRL_WARN_DIRTY_BIT] && !warn_field_hit |=> !warning_flag_o)
    else $error("warning flag without an enabled cause");
  zero_word_a: assert property (!seq_bus.free |=> {slave_input_bit_three_o, slave_input_bit_two_o,
                                slave_input_bit_one_o, slave_input_bit_zero_o} == 4'h0)
    else $error("non-zero word while not free");
  seq_restart_a: assert property (seq_bus.free ##1 !seq_bus.free |=> seq_bus.idx == 3'h0)
    else $error("sequence index not restarted after leaving free");
endmodule : sbcs_top

// *** testbench/sbcs_poll_model.sv ***
`timescale 1ns/1ps
module sbcs_poll_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [3:0] gap_i,
  input  wire logic [3:0] nibble_i,
  output logic            poll_done_o,
  output logic      [1:0] mon_free_o
);
  logic [3:0] cnt_reg;
  logic [2:0] mon_idx_reg [2];
  // gap 0 gives back-to-back polls, larger gaps a slow master
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg     <= 4'h0;
      poll_done_o <= 1'b0;
    end
    else
    begin
      poll_done_o <= en_i && (cnt_reg == gap_i);
      cnt_reg     <= (!en_i || cnt_reg == gap_i) ? 4'h0 : cnt_reg + 4'h1;
    end
  end

  // two listeners, each keeps its own place in the sequence and never polls
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mon_idx_reg[0] <= 3'h0;
      mon_idx_reg[1] <= 3'h0;
      mon_free_o     <= 2'h0;
    end
    else if (poll_done_o)
    begin
      for (int m = 0; m < 2; m++)
      begin
        if (nibble_i == sbcs_pkg::CODE_TABLE_DEFAULT[4*mon_idx_reg[m] +: 4])
        begin
          mon_idx_reg[m] <= mon_idx_reg[m] + 3'h1;
          mon_free_o[m]  <= 1'b1;
        end
        else
        begin
          // any wrong word, the zero word too, switches off at once
          mon_idx_reg[m] <= 3'h0;
          mon_free_o[m]  <= 1'b0;
        end
      end
    end
  end
endmodule : sbcs_poll_model

// *** testbench/tb_safe_bus_slave_code_sequencer.sv ***
`timescale 1ns/1ps
module tb_safe_bus_slave_code_sequencer;
  import sbcs_pkg::*;
  logic                 clk, rst_n, wr, rd, dirty, rs, poll, safe, warn, irq, pen;
  logic                 b0, b1, b2, b3;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wd, rdat, d;
  logic [PAIR_W-1:0]    sel;
  logic [NUM_PAIRS-1:0] ph, wh;
  logic [3:0]           gap;
  logic [1:0]           mon;
  int                   err_total, n_tests, pos;
  wire  [3:0]           nib = {b3, b2, b1, b0};

  sbcs_top sbcs_top_i (.clk_i(clk), .resetn_i(rst_n), .addr_i(addr), .wr_data_i(wd), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .field_sel_i(sel), .protect_hit_i(ph), .warn_hit_i(wh),
    .window_dirty_i(dirty), .restart_button_i(rs), .poll_done_i(poll), .safety_switch_output_o(safe),
    .warning_flag_o(warn), .slave_input_bit_zero_o(b0), .slave_input_bit_one_o(b1),
    .slave_input_bit_two_o(b2), .slave_input_bit_three_o(b3), .irq_o(irq));
  sbcs_poll_model sbcs_poll_model_i (.clk_i(clk), .rst_n_i(rst_n), .en_i(pen), .gap_i(gap),
    .nibble_i(nib), .poll_done_o(poll), .mon_free_o(mon));

  always #4 clk = ~clk;

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wd   <= v;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdat;
  endtask : rd_reg

  // a hang in a wait ends the run through the verdict
  task automatic wait_sig(input logic v, input bit on_poll);
    for (int i = 0; i < 20 && (on_poll ? poll : safe) !== v; i++)
      tick(1);
    if ((on_poll ? poll : safe) !== v)
    begin
      err_total++;
      print_verdict();
    end
  endtask : wait_sig

  function automatic logic [3:0] ent(input int i);
    return CODE_TABLE_DEFAULT[4*(i%SEQ_LEN) +: 4];
  endfunction : ent

  task automatic t_regs();
    rd_reg(CTRL_OFS);
    chk(d, 32'h6);
    rd_reg(IRQ_MASK_OFS);
    chk(d, 32'h0);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_reg(8'h10);
    chk(d, 32'h0);
    rd_reg(STATUS_OFS);
    chk(d, 32'h0d);
    wr_reg(IRQ_MASK_OFS, 32'h7);
  endtask : t_regs

  task automatic t_seq(input logic [3:0] g);
    tick(1);
    chk(nib, ent(pos));
    gap <= g;
    pen <= 1'b1;
    for (int k = 1; k <= 17; k++)
    begin
      wait_sig(1'b1, 1'b1);
      tick(1);
      pos++;
      chk(nib, ent(pos));
    end
    chk(mon, 2'h3);
    pen <= 1'b0;
    // a poll already launched by the master still reaches the slave
    if (poll)
      pos++;
  endtask : t_seq

  task automatic t_trip();
    @(posedge clk);
    sel <= 2'h1;
    ph  <= 4'h4;
    tick(3);
    chk(safe, 1'b1);
    ph <= 4'h2;
    tick(1);
    chk({safe, nib}, {1'b0, ent(pos)});
    tick(1);
    chk(nib, 4'h0);
    for (int k = 0; k < 4; k++)
    begin
      tick(1);
      chk({safe, nib}, 5'h0);
    end
    gap <= 4'h0;
    pen <= 1'b1;
    wait_sig(1'b1, 1'b1);
    tick(1);
    chk(mon, 2'h0);
    pen <= 1'b0;
    chk(irq, 1'b1);
    rd_reg(IRQ_STAT_OFS);
    chk(d, 32'h5);
    wr_reg(IRQ_STAT_OFS, 32'h5);
    wr_reg(IRQ_MASK_OFS, 32'h0);
    tick(1);
    chk(irq, 1'b0);
    ph <= 4'h0;
    wait_sig(1'b1, 1'b0);
    tick(1);
    chk(nib, ent(0));
    chk(irq, 1'b0);
    wr_reg(IRQ_MASK_OFS, 32'h4);
    tick(1);
    chk(irq, 1'b1);
    wr_reg(IRQ_STAT_OFS, 32'h4);
    tick(1);
    chk(irq, 1'b0);
  endtask : t_trip

  task automatic t_warn();
    wh <= 4'h2;
    tick(2);
    chk({safe, warn}, 2'h3);
    wh <= 4'h1;
    tick(2);
    chk(warn, 1'b0);
    dirty <= 1'b1;
    tick(2);
    chk(warn, 1'b1);
    wr_reg(CTRL_OFS, 32'h0);
    tick(1);
    chk(warn, 1'b0);
    dirty <= 1'b0;
    wr_reg(CTRL_OFS, 32'h7);
  endtask : t_warn

  task automatic t_ack();
    ph <= 4'h2;
    wait_sig(1'b0, 1'b0);
    rs <= 1'b1;
    tick(2);
    rs <= 1'b0;
    ph <= 4'h0;
    tick(4);
    chk(safe, 1'b0);
    rd_reg(STATUS_OFS);
    chk(d[3:2], 2'b01);
    rs <= 1'b1;
    tick(1);
    rs <= 1'b0;
    wait_sig(1'b1, 1'b0);
    ph <= 4'h2;
    wait_sig(1'b0, 1'b0);
    ph <= 4'h0;
    tick(2);
    chk(safe, 1'b0);
    wr_reg(CTRL_OFS, 32'hf);
    tick(1);
    chk(safe, 1'b1);
  endtask : t_ack

  initial
  begin
    {clk, rst_n, wr, rd, dirty, rs, pen, addr, wd, sel, ph, wh, gap} = '0;
    err_total = 0;
    n_tests   = 0;
    pos       = 0;
    tick(3);
    chk({safe, warn, irq, nib}, 7'h0);
    rst_n <= 1'b1;
    tick(3);
    wait_sig(1'b1, 1'b0);
    t_regs();
    t_seq(4'h0);
    t_seq(4'h3);
    t_trip();
    t_warn();
    t_ack();
    print_verdict();
  end
endmodule : tb_safe_bus_slave_code_sequencer
